// >>> design/lpfs_pin_select.sv
`timescale 1ns/1ps
module lpfs_pin_select
   import lpfs_pkg::*;
#(
   parameter int SYNC_STAGES = 2
)
(
   input wire logic CLOCK,
   input wire logic SYS_RST,
   input wire logic [ADDR_W-1:0] REG_ADDR,
   input wire logic [DATA_W-1:0] REG_WDATA,
   input wire logic REG_WR,
   input wire logic REG_RD,
   output logic [DATA_W-1:0] REG_RDATA,
   input wire lpfs_timing_s TIMING_IN,
   input wire lpfs_ctrl_s PANEL_CTRL_IN,
   input wire lpfs_serial_s SERIAL_IN,
   output logic [SHARED_PINS-1:0] SERIAL_PIN_LEVEL,
   output logic [LOW_DATA_W-1:0] PANEL_DATA_LOW,
   output logic PANEL_FRAME_PULSE,
   output logic PANEL_LINE_PULSE,
   output logic PANEL_SHIFT_CLOCK,
   output logic PANEL_ENABLE_OR_BIAS,
   input wire logic [SHARED_PINS-1:0] SHARED_PIN_IN,
   output logic [SHARED_PINS-1:0] SHARED_PIN_OUT,
   output logic [SHARED_PINS-1:0] SHARED_PIN_OE,
   output logic [SHARED_PINS-1:0] SHARED_PIN_PULLDOWN,
   input wire logic [UPPER_PINS-1:0] UPPER_PIN_IN,
   output logic [UPPER_PINS-1:0] UPPER_PIN_OUT,
   output logic [UPPER_PINS-1:0] UPPER_PIN_OE,
   output logic [UPPER_PINS-1:0] UPPER_PIN_PULLDOWN
);

   // ==========================================
   // Elaboration checks
   generate
      if (SYNC_STAGES < 2)
      begin : g_bad_sync
         $error("SYNC_STAGES must be at least 2");
      end
   endgenerate

   // ==========================================
   // Address decode
   function automatic lpfs_rsel_e decode(input logic [ADDR_W-1:0] addr);
      unique case (addr)
         PULLDOWN_ADDR: decode = RSEL_PULLDOWN;
         PIN_SELECT_ADDR: decode = RSEL_PIN_SELECT;
         PANEL_CONFIG_ADDR: decode = RSEL_PANEL_CONFIG;
         PIN_DATA_ADDR: decode = RSEL_PIN_DATA;
         UPPER_DIR_ADDR: decode = RSEL_UPPER_DIR;
         default: decode = RSEL_NONE;
      endcase
   endfunction

   // Shared pin function mux: returns {out, oe}
   function automatic logic [1:0] shared_mux(
      input logic [1:0] sel,
      input logic gen_out,
      input logic ctrl,
      input logic ser_out,
      input logic ser_oe
   );
      unique case (lpfs_func_e'(sel))
         FUNC_GEN_IN: shared_mux = 2'h0;
         FUNC_PANEL: shared_mux = {ctrl, 1'b1};
         FUNC_GEN_OUT: shared_mux = {gen_out, 1'b1};
         FUNC_SERIAL: shared_mux = {ser_out, ser_oe};
      endcase
   endfunction

   lpfs_rsel_e wr_sel;
   lpfs_rsel_e rd_sel;
   logic [DATA_W-1:0] pulldown_reg;
   logic [DATA_W-1:0] pin_select_reg;
   logic [DATA_W-1:0] panel_config_reg;
   logic [DATA_W-1:0] pin_data_reg;
   logic [DATA_W-1:0] upper_dir_reg;
   logic [DATA_W-1:0] rdata_next;
   logic [DATA_W-1:0] rdata_reg;
   logic [SYNC_STAGES*SHARED_PINS-1:0] shared_sync_reg;
   logic [SYNC_STAGES*UPPER_PINS-1:0] upper_sync_reg;
   logic [SHARED_PINS-1:0] shared_level;
   logic [UPPER_PINS-1:0] upper_level;
   logic wide_panel;
   logic tft_panel;
   logic [SHARED_PINS-1:0] ctrl_vec;
   wire logic [SHARED_PINS-1:0] shared_out_next;
   wire logic [SHARED_PINS-1:0] shared_oe_next;

   assign wr_sel = decode(REG_ADDR);
   assign rd_sel = decode(REG_ADDR);
   assign wide_panel = (panel_config_reg[WIDTH_LSB +: 3] == WIDTH_24BIT);
   assign tft_panel = panel_config_reg[PANEL_TFT_BIT];
   assign ctrl_vec = {PANEL_CTRL_IN.right_shift_start, PANEL_CTRL_IN.left_shift_start,
                      PANEL_CTRL_IN.polarity_reverse, PANEL_CTRL_IN.gate_clock_control};

   // ==========================================
   // Configuration registers
   always_ff @(posedge CLOCK)
   begin
      if (SYS_RST)
      begin
         pin_select_reg <= PIN_SELECT_RESET;
      end
      else if (REG_WR && wr_sel == RSEL_PIN_SELECT)
      begin
         pin_select_reg <= REG_WDATA & PIN_SELECT_MASK;
      end
   end

   always_ff @(posedge CLOCK)
   begin
      if (SYS_RST)
      begin
         pulldown_reg <= PULLDOWN_RESET;
      end
      else if (REG_WR && wr_sel == RSEL_PULLDOWN)
      begin
         pulldown_reg <= REG_WDATA & PULLDOWN_MASK;
      end
   end

   always_ff @(posedge CLOCK)
   begin
      if (SYS_RST)
      begin
         panel_config_reg <= PANEL_CONFIG_RESET;
      end
      else if (REG_WR && wr_sel == RSEL_PANEL_CONFIG)
      begin
         panel_config_reg <= REG_WDATA & PANEL_CONFIG_MASK;
      end
   end

   always_ff @(posedge CLOCK)
   begin
      if (SYS_RST)
      begin
         pin_data_reg <= PIN_DATA_RESET;
      end
      else if (REG_WR && wr_sel == RSEL_PIN_DATA)
      begin
         pin_data_reg <= REG_WDATA & PIN_DATA_MASK;
      end
   end

   always_ff @(posedge CLOCK)
   begin
      if (SYS_RST)
      begin
         upper_dir_reg <= UPPER_DIR_RESET;
      end
      else if (REG_WR && wr_sel == RSEL_UPPER_DIR)
      begin
         upper_dir_reg <= REG_WDATA & UPPER_DIR_MASK;
      end
   end

   // ==========================================
   // Read port
   always_comb
   begin
      rdata_next = '0;
      if (REG_RD)
      begin
         unique case (rd_sel)
            RSEL_PULLDOWN: rdata_next = pulldown_reg;
            RSEL_PIN_SELECT: rdata_next = pin_select_reg;
            RSEL_PANEL_CONFIG: rdata_next = panel_config_reg;
            RSEL_PIN_DATA:
               rdata_next = {6'h00, upper_level, shared_level};
            RSEL_UPPER_DIR: rdata_next = upper_dir_reg;
            RSEL_NONE: rdata_next = '0;
         endcase
      end
   end

   always_ff @(posedge CLOCK)
   begin
      if (SYS_RST)
      begin
         rdata_reg <= '0;
      end
      else
      begin
         rdata_reg <= rdata_next;
      end
   end

   assign REG_RDATA = rdata_reg;

   // ==========================================
   // Pin input synchronisers
   always_ff @(posedge CLOCK)
   begin
      if (SYS_RST)
      begin
         shared_sync_reg <= '0;
         upper_sync_reg <= '0;
      end
      else
      begin
         shared_sync_reg <= {shared_sync_reg[(SYNC_STAGES-1)*SHARED_PINS-1:0], SHARED_PIN_IN};
         upper_sync_reg <= {upper_sync_reg[(SYNC_STAGES-1)*UPPER_PINS-1:0], UPPER_PIN_IN};
      end
   end

   assign shared_level = shared_sync_reg[SYNC_STAGES*SHARED_PINS-1 -: SHARED_PINS];
   assign upper_level = upper_sync_reg[SYNC_STAGES*UPPER_PINS-1 -: UPPER_PINS];
   assign SERIAL_PIN_LEVEL = shared_level;

   // ==========================================
   // Panel timing outputs
   always_ff @(posedge CLOCK)
   begin
      if (SYS_RST)
      begin
         PANEL_DATA_LOW <= '0;
         PANEL_FRAME_PULSE <= 1'b0;
         PANEL_LINE_PULSE <= 1'b0;
         PANEL_SHIFT_CLOCK <= 1'b0;
         PANEL_ENABLE_OR_BIAS <= 1'b0;
      end
      else
      begin
         PANEL_DATA_LOW <= TIMING_IN.data[LOW_DATA_W-1:0];
         PANEL_FRAME_PULSE <= TIMING_IN.frame;
         PANEL_LINE_PULSE <= TIMING_IN.line;
         PANEL_SHIFT_CLOCK <= TIMING_IN.shift;
         PANEL_ENABLE_OR_BIAS <= tft_panel ? TIMING_IN.display_enable
                                           : TIMING_IN.backplane_bias;
      end
   end

   // ==========================================
   // Shared pins
   genvar i;
   generate
      for (i = 0; i < SHARED_PINS; i++)
      begin : g_shared
         assign {shared_out_next[i], shared_oe_next[i]} =
            shared_mux(pin_select_reg[SEL_FIRST_LSB + SEL_W*i +: SEL_W],
                       pin_data_reg[SHARED_OUT_LSB + i], ctrl_vec[i],
                       SERIAL_IN.out[i], SERIAL_IN.oe[i]);
      end
   endgenerate

   // One register stage for all shared pins
   always_ff @(posedge CLOCK)
   begin
      if (SYS_RST)
      begin
         SHARED_PIN_OUT <= '0;
         SHARED_PIN_OE <= '0;
         SHARED_PIN_PULLDOWN <= '0;
      end
      else
      begin
         SHARED_PIN_OUT <= shared_out_next;
         SHARED_PIN_OE <= shared_oe_next;
         SHARED_PIN_PULLDOWN <= pulldown_reg[PD_SHARED_LSB +: SHARED_PINS];
      end
   end

   // ==========================================
   // Upper data pins
   always_ff @(posedge CLOCK)
   begin
      if (SYS_RST)
      begin
         UPPER_PIN_OUT <= '0;
         UPPER_PIN_OE <= '0;
         UPPER_PIN_PULLDOWN <= '0;
      end
      else
      begin
         UPPER_PIN_PULLDOWN <= pulldown_reg[PD_UPPER_LSB +: UPPER_PINS];
         if (wide_panel)
         begin
            UPPER_PIN_OUT <= TIMING_IN.data[PANEL_DATA_W-1:LOW_DATA_W];
            UPPER_PIN_OE <= '1;
         end
         else
         begin
            UPPER_PIN_OUT <= pin_data_reg[UPPER_OUT_LSB +: UPPER_PINS];
            UPPER_PIN_OE <= upper_dir_reg[UPPER_PINS-1:0];
         end
      end
   end

endmodule // lpfs_pin_select

// >>> design/lpfs_pkg.sv
package lpfs_pkg;

   // ==========================================
   // Register bus
   localparam int ADDR_W = 16;
   localparam int DATA_W = 16;
   localparam logic [15:0] PULLDOWN_ADDR = 16'h0468;
   localparam logic [15:0] PIN_SELECT_ADDR = 16'h0c1a;
   localparam logic [15:0] PANEL_CONFIG_ADDR = 16'h0800;
   localparam logic [15:0] PIN_DATA_ADDR = 16'h0c20;
   localparam logic [15:0] UPPER_DIR_ADDR = 16'h0c22;

   // ==========================================
   // Writable bits and reset values
   localparam logic [15:0] PIN_SELECT_MASK = 16'h03fc;
   localparam logic [15:0] PULLDOWN_MASK = 16'h3f1e;
   localparam logic [15:0] PANEL_CONFIG_MASK = 16'h0780;
   localparam logic [15:0] PIN_DATA_MASK = 16'h03ff;
   localparam logic [15:0] UPPER_DIR_MASK = 16'h003f;
   localparam logic [15:0] PIN_SELECT_RESET = 16'h0000;
   localparam logic [15:0] PULLDOWN_RESET = 16'h0000;
   localparam logic [15:0] PANEL_CONFIG_RESET = 16'h0000;
   localparam logic [15:0] PIN_DATA_RESET = 16'h0000;
   localparam logic [15:0] UPPER_DIR_RESET = 16'h0000;

   // ==========================================
   // Field positions
   localparam int SEL_FIRST_LSB = 2;
   localparam int SEL_W = 2;
   localparam int PD_SHARED_LSB = 1;
   localparam int PD_UPPER_LSB = 8;
   localparam int WIDTH_LSB = 8;
   localparam logic [2:0] WIDTH_24BIT = 3'h3;
   localparam int PANEL_TFT_BIT = 7;
   localparam int SHARED_OUT_LSB = 0;
   localparam int UPPER_OUT_LSB = 4;
   localparam int SHARED_PINS = 4;
   localparam int UPPER_PINS = 6;
   localparam int LOW_DATA_W = 18;
   localparam int PANEL_DATA_W = 24;

   // ==========================================
   // Types
   typedef enum logic [1:0] {FUNC_GEN_IN, FUNC_PANEL, FUNC_GEN_OUT, FUNC_SERIAL} lpfs_func_e;
   typedef enum logic [2:0] {
      RSEL_NONE, RSEL_PULLDOWN, RSEL_PIN_SELECT, RSEL_PANEL_CONFIG, RSEL_PIN_DATA, RSEL_UPPER_DIR
   } lpfs_rsel_e;

   typedef struct packed {
      logic [PANEL_DATA_W-1:0] data;
      logic frame;
      logic line;
      logic shift;
      logic display_enable;
      logic backplane_bias;
   } lpfs_timing_s;

   typedef struct packed {
      logic right_shift_start;
      logic left_shift_start;
      logic polarity_reverse;
      logic gate_clock_control;
   } lpfs_ctrl_s;

   typedef struct packed {
      logic [SHARED_PINS-1:0] out;
      logic [SHARED_PINS-1:0] oe;
   } lpfs_serial_s;

endpackage

// >>> tb/lpfs_panel_model.sv
`timescale 1ns/1ps
module lpfs_panel_model
#(
   parameter int N = 4
)
(
   input wire logic CLOCK,
   input wire logic [N-1:0] out,
   input wire logic [N-1:0] oe,
   input wire logic [N-1:0] pd,
   output logic [N-1:0] level
);
   // ==========
   // Pin levels
   logic [N-1:0] wobble = '0;
   always @(posedge CLOCK) wobble <= ~wobble;
   // Pull-down holds a released pin low, else it floats
   assign level = (oe & out) | (~oe & ~pd & wobble);
endmodule // lpfs_panel_model

// >>> tb/lpfs_pin_select_properties.sv
`timescale 1ns/1ps
module lpfs_chk
   import lpfs_pkg::*;
(
   input wire logic CLOCK,
   input wire logic SYS_RST,
   input wire logic [ADDR_W-1:0] REG_ADDR,
   input wire logic [DATA_W-1:0] REG_WDATA,
   input wire logic REG_WR,
   input wire lpfs_timing_s TIMING_IN,
   input wire logic [LOW_DATA_W-1:0] PANEL_DATA_LOW,
   input wire logic PANEL_FRAME_PULSE,
   input wire logic PANEL_LINE_PULSE,
   input wire logic PANEL_SHIFT_CLOCK,
   input wire logic PANEL_ENABLE_OR_BIAS,
   input wire logic [SHARED_PINS-1:0] SHARED_PIN_OE,
   input wire logic [SHARED_PINS-1:0] SHARED_PIN_PULLDOWN,
   input wire logic [UPPER_PINS-1:0] UPPER_PIN_OE,
   input wire logic [UPPER_PINS-1:0] UPPER_PIN_PULLDOWN
);
   default clocking @(posedge CLOCK); endclocking
   default disable iff (SYS_RST);
   // ==========
   // Properties
   property p_data;
      !$past(SYS_RST) |-> PANEL_DATA_LOW == $past(TIMING_IN.data[17:0]);
   endproperty
   a_data: assert property (p_data) else $error("panel data wrong");
   property p_frame;
      !$past(SYS_RST) |-> PANEL_FRAME_PULSE == $past(TIMING_IN.frame);
   endproperty
   a_frame: assert property (p_frame) else $error("frame pulse wrong");
   property p_line;
      !$past(SYS_RST) |-> PANEL_LINE_PULSE == $past(TIMING_IN.line);
   endproperty
   a_line: assert property (p_line) else $error("line pulse wrong");
   property p_shift;
      !$past(SYS_RST) |-> PANEL_SHIFT_CLOCK == $past(TIMING_IN.shift);
   endproperty
   a_shift: assert property (p_shift) else $error("shift clock wrong");
   property p_rst;
      $past(SYS_RST) |-> {PANEL_DATA_LOW, PANEL_FRAME_PULSE, PANEL_LINE_PULSE,
         PANEL_SHIFT_CLOCK, PANEL_ENABLE_OR_BIAS} == '0;
   endproperty
   a_rst: assert property (p_rst) else $error("panel outputs not low");
   property p_pdu;
      REG_WR && REG_ADDR == PULLDOWN_ADDR |-> ##2 UPPER_PIN_PULLDOWN == $past(REG_WDATA[13:8], 2);
   endproperty
   a_pdu: assert property (p_pdu) else $error("upper pull-down wrong");
   property p_pds;
      REG_WR && REG_ADDR == PULLDOWN_ADDR |-> ##2 SHARED_PIN_PULLDOWN == $past(REG_WDATA[4:1], 2);
   endproperty
   a_pds: assert property (p_pds) else $error("shared pull-down wrong");
   property p_oe4;
      REG_WR && REG_ADDR == PIN_SELECT_ADDR && REG_WDATA[9:8] != 2'h3
         |-> ##2 SHARED_PIN_OE[3] == ($past(REG_WDATA[9:8], 2) != 2'h0);
   endproperty
   a_oe4: assert property (p_oe4) else $error("pin 4 enable wrong");
   property p_oe1;
      REG_WR && REG_ADDR == PIN_SELECT_ADDR && REG_WDATA[3:2] != 2'h3
         |-> ##2 SHARED_PIN_OE[0] == ($past(REG_WDATA[3:2], 2) != 2'h0);
   endproperty
   a_oe1: assert property (p_oe1) else $error("pin 1 enable wrong");
   property p_oe3;
      REG_WR && REG_ADDR == PIN_SELECT_ADDR && REG_WDATA[7:6] != 2'h3
         |-> ##2 SHARED_PIN_OE[2] == ($past(REG_WDATA[7:6], 2) != 2'h0);
   endproperty
   a_oe3: assert property (p_oe3) else $error("pin 3 enable wrong");
   property p_oe2;
      REG_WR && REG_ADDR == PIN_SELECT_ADDR && REG_WDATA[5:4] != 2'h3
         |-> ##2 SHARED_PIN_OE[1] == ($past(REG_WDATA[5:4], 2) != 2'h0);
   endproperty
   a_oe2: assert property (p_oe2) else $error("pin 2 enable wrong");
   property p_wide;
      REG_WR && REG_ADDR == PANEL_CONFIG_ADDR && REG_WDATA[10:8] == 3'h3
         |-> ##2 UPPER_PIN_OE == 6'h3f;
   endproperty
   a_wide: assert property (p_wide) else $error("upper pins not driven");
endmodule // lpfs_chk

// >>> tb/lpfs_pin_select_test.sv
`timescale 1ns/1ps
module lpfs_pin_select_test;
   import lpfs_pkg::*;
   logic CLOCK = 0, SYS_RST = 1, REG_WR = 0, REG_RD = 0;
   logic [15:0] REG_ADDR = '0, REG_WDATA = '0, REG_RDATA;
   lpfs_timing_s TIMING_IN = '1;
   lpfs_ctrl_s PANEL_CTRL_IN = 4'h5;
   lpfs_serial_s SERIAL_IN = 8'h36;
   logic [3:0] SERIAL_PIN_LEVEL, SHARED_PIN_IN, SHARED_PIN_OUT, SHARED_PIN_OE, SHARED_PIN_PULLDOWN;
   logic [17:0] PANEL_DATA_LOW;
   logic PANEL_FRAME_PULSE, PANEL_LINE_PULSE, PANEL_SHIFT_CLOCK, PANEL_ENABLE_OR_BIAS;
   logic [5:0] UPPER_PIN_IN, UPPER_PIN_OUT, UPPER_PIN_OE, UPPER_PIN_PULLDOWN;
   int err_count = 0, check_count = 0;
   always #10 CLOCK = ~CLOCK;
   lpfs_pin_select uut (
      .CLOCK(CLOCK),
      .SYS_RST(SYS_RST),
      .REG_ADDR(REG_ADDR),
      .REG_WDATA(REG_WDATA),
      .REG_WR(REG_WR),
      .REG_RD(REG_RD),
      .REG_RDATA(REG_RDATA),
      .TIMING_IN(TIMING_IN),
      .PANEL_CTRL_IN(PANEL_CTRL_IN),
      .SERIAL_IN(SERIAL_IN),
      .SERIAL_PIN_LEVEL(SERIAL_PIN_LEVEL),
      .PANEL_DATA_LOW(PANEL_DATA_LOW),
      .PANEL_FRAME_PULSE(PANEL_FRAME_PULSE),
      .PANEL_LINE_PULSE(PANEL_LINE_PULSE),
      .PANEL_SHIFT_CLOCK(PANEL_SHIFT_CLOCK),
      .PANEL_ENABLE_OR_BIAS(PANEL_ENABLE_OR_BIAS),
      .SHARED_PIN_IN(SHARED_PIN_IN),
      .SHARED_PIN_OUT(SHARED_PIN_OUT),
      .SHARED_PIN_OE(SHARED_PIN_OE),
      .SHARED_PIN_PULLDOWN(SHARED_PIN_PULLDOWN),
      .UPPER_PIN_IN(UPPER_PIN_IN),
      .UPPER_PIN_OUT(UPPER_PIN_OUT),
      .UPPER_PIN_OE(UPPER_PIN_OE),
      .UPPER_PIN_PULLDOWN(UPPER_PIN_PULLDOWN)
   );
   lpfs_panel_model #(.N(4)) shared_side (.CLOCK, .out(SHARED_PIN_OUT), .oe(SHARED_PIN_OE),
      .pd(SHARED_PIN_PULLDOWN), .level(SHARED_PIN_IN));
   lpfs_panel_model #(.N(6)) upper_side (.CLOCK, .out(UPPER_PIN_OUT), .oe(UPPER_PIN_OE),
      .pd(UPPER_PIN_PULLDOWN), .level(UPPER_PIN_IN));
   // ==========
   // Tasks
   task chk(input string n, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (e !== g)
      begin
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
         err_count++;
      end
   endtask
   task wr(input logic [15:0] a, input logic [15:0] d);
      @(posedge CLOCK);
      REG_WR <= 1;
      REG_ADDR <= a;
      REG_WDATA <= d;
      @(posedge CLOCK);
      REG_WR <= 0;
   endtask
   task rd(input logic [15:0] a, input logic [15:0] e);
      @(posedge CLOCK);
      REG_RD <= 1;
      REG_ADDR <= a;
      @(posedge CLOCK);
      REG_RD <= 0;
      #1 chk("read", e, REG_RDATA);
   endtask
   task settle(input int n);
      repeat (n) @(posedge CLOCK);
      #1;
   endtask
   task t_panel(input logic [28:0] p, input logic tft);
      wr(PANEL_CONFIG_ADDR, {8'h00, tft, 7'h00});
      @(posedge CLOCK);
      TIMING_IN <= p;
      @(posedge CLOCK);
      #1 chk("data", p[22:5], PANEL_DATA_LOW);
      chk("pulses", p[4:2], {PANEL_FRAME_PULSE, PANEL_LINE_PULSE, PANEL_SHIFT_CLOCK});
      chk("enable", tft ? p[1] : p[0], PANEL_ENABLE_OR_BIAS);
   endtask
   task t_sel;
      logic [3:0] pd;
      logic oe_e, out_e;
      pd = 4'ha;
      wr(PIN_DATA_ADDR, 16'h000a);
      for (int i = 0; i < 4; i++)
         for (int s = 0; s < 4; s++)
         begin
            wr(PIN_SELECT_ADDR, 16'(s << (2 + 2 * i)));
            settle(3);
            oe_e = (s == 3) ? SERIAL_IN.oe[i] : (s != 0);
            out_e = (s == 1) ? PANEL_CTRL_IN[i] : (s == 2) ? pd[i] : SERIAL_IN.out[i];
            chk("pin enable", oe_e, SHARED_PIN_OE[i]);
            if (oe_e)
               chk("pin out", out_e, SHARED_PIN_OUT[i]);
         end
   endtask
   task t_pull;
      wr(PIN_SELECT_ADDR, 16'h0000);
      wr(PULLDOWN_ADDR, 16'hffff);
      settle(5);
      chk("pulldowns", 10'h3ff, {UPPER_PIN_PULLDOWN, SHARED_PIN_PULLDOWN});
      rd(PULLDOWN_ADDR, 16'h3f1e);
      rd(PIN_DATA_ADDR, 16'h0000);
      wr(PULLDOWN_ADDR, 16'h0a14);
      settle(3);
      chk("pulldowns", 10'h0aa, {UPPER_PIN_PULLDOWN, SHARED_PIN_PULLDOWN});
   endtask
   task t_gpo;
      wr(PIN_SELECT_ADDR, 16'hffff);
      rd(PIN_SELECT_ADDR, 16'h03fc);
      wr(PIN_SELECT_ADDR, 16'h02a8);
      wr(UPPER_DIR_ADDR, 16'h003f);
      wr(PIN_DATA_ADDR, 16'h02d6);
      settle(6);
      chk("serial level", 4'h6, SERIAL_PIN_LEVEL);
      rd(PIN_DATA_ADDR, 16'h02d6);
      rd(16'h0c24, 16'h0000);
      wr(UPPER_DIR_ADDR, 16'h0000);
      wr(PANEL_CONFIG_ADDR, 16'h0300);
      TIMING_IN <= {6'h2b, 23'h0};
      settle(3);
      chk("upper", 12'hfeb, {UPPER_PIN_OE, UPPER_PIN_OUT});
      wr(PANEL_CONFIG_ADDR, 16'h0100);
      settle(3);
      chk("upper", 12'h02d, {UPPER_PIN_OE, UPPER_PIN_OUT});
   endtask
   task print_verdict;
      if (err_count == 0 && check_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // ==========
   // Sequence
   initial
   begin
      settle(2);
      chk("reset outputs", 0, {PANEL_DATA_LOW, PANEL_FRAME_PULSE, PANEL_ENABLE_OR_BIAS});
      chk("reset outputs", 0, {PANEL_LINE_PULSE, PANEL_SHIFT_CLOCK, SHARED_PIN_OE});
      @(posedge CLOCK);
      SYS_RST <= 0;
      rd(PIN_SELECT_ADDR, 16'h0000);
      t_panel(29'h15555556, 1'b1);
      t_panel(29'h0aaaaaa9, 1'b0);
      t_sel();
      t_pull();
      t_gpo();
      print_verdict();
   end
endmodule // lpfs_pin_select_test

bind lpfs_pin_select lpfs_chk u_chk (
   .CLOCK(CLOCK),
   .SYS_RST(SYS_RST),
   .REG_ADDR(REG_ADDR),
   .REG_WDATA(REG_WDATA),
   .REG_WR(REG_WR),
   .TIMING_IN(TIMING_IN),
   .PANEL_DATA_LOW(PANEL_DATA_LOW),
   .PANEL_FRAME_PULSE(PANEL_FRAME_PULSE),
   .PANEL_LINE_PULSE(PANEL_LINE_PULSE),
   .PANEL_SHIFT_CLOCK(PANEL_SHIFT_CLOCK),
   .PANEL_ENABLE_OR_BIAS(PANEL_ENABLE_OR_BIAS),
   .SHARED_PIN_OE(SHARED_PIN_OE),
   .SHARED_PIN_PULLDOWN(SHARED_PIN_PULLDOWN),
   .UPPER_PIN_OE(UPPER_PIN_OE),
   .UPPER_PIN_PULLDOWN(UPPER_PIN_PULLDOWN)
);
